// ---- logic/gpio_level_pkg.sv ----
// Constants for the twelve-pin level register block.
// Assumes a 16-bit register port and one 25 MHz clock.
package gpio_level_pkg;
    localparam int          PIN_COUNT      = 12;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 16;
    localparam int          FN_W           = 4;
    localparam int          FN_PER_REG     = 4;
    // Register offsets
    localparam logic [15:0] PIN_LEVEL_ADDR = 16'h400c;
    localparam logic [15:0] PIN_DIR_ADDR   = 16'h4100;
    localparam logic [15:0] PIN_POL_ADDR   = 16'h4101;
    localparam logic [15:0] PIN_FN0_ADDR   = 16'h4102;
    localparam logic [15:0] PIN_FN1_ADDR   = 16'h4103;
    localparam logic [15:0] PIN_FN2_ADDR   = 16'h4104;
    // Field values
    localparam logic [3:0]  FN_PLAIN_GPIO  = 4'h0;
    localparam logic        DIR_OUTPUT     = 1'b0;
    localparam logic        POL_INVERT     = 1'b0;
    // Reset values
    localparam logic [11:0] LEVEL_RESET    = 12'h000;
    localparam logic [11:0] DIR_RESET      = 12'hfff;
    localparam logic [11:0] POL_RESET      = 12'hfff;
    localparam logic [15:0] FN_RESET       = 16'h0000;
    localparam logic [15:0] UNMAPPED_READ  = 16'h0000;
    localparam logic [3:0]  UPPER_ZERO     = 4'h0;
endpackage : gpio_level_pkg

// ---- logic/pin_level_cell.sv ----
// One pin's level logic: output gating and polarity for reads and drives.
// Assumes the function, direction and polarity settings are stable levels.
`timescale 1ns/1ps
module pin_level_cell
    import gpio_level_pkg::*;
(
    input  wire logic            i_level,
    input  wire logic            i_pin_in,
    input  wire logic            i_polarity,
    input  wire logic            i_direction,
    input  wire logic [FN_W-1:0] i_function_select,
    output logic                 o_out_enabled,
    output logic                 o_drive,
    output logic                 o_read_bit
);
    // Output only in plain function with output direction
    assign o_out_enabled = (i_function_select == FN_PLAIN_GPIO) &&
                           (i_direction == DIR_OUTPUT);
    // Inverted sense when polarity is zero, both ways
    assign o_drive    = (i_polarity == POL_INVERT) ? ~i_level
                                                   : i_level;
    assign o_read_bit = (i_polarity == POL_INVERT) ? ~i_pin_in
                                                   : i_pin_in;
endmodule : pin_level_cell

// ---- logic/gpio_level_register.sv ----
// Level register for twelve general-purpose pins plus their settings.
// Assumes pin inputs synchronous to i_clk and a one-cycle strobe master.
`timescale 1ns/1ps
module gpio_level_register
    import gpio_level_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              i_wr_en,
    input  wire logic              i_rd_en,
    output logic [DATA_W-1:0]      o_rd_data,
    input  wire logic [11:0]       i_pin_in,
    output logic [11:0]            o_pin_out,
    output logic [11:0]            o_pin_oe
);
    ////////////////////////////////////////////////////////////////////
    logic [11:0]             level;
    logic [11:0]             direction;
    logic [11:0]             polarity;
    logic [DATA_W-1:0]       fn_reg [3];
    logic [FN_W-1:0]         fn_sel [PIN_COUNT];
    logic [11:0]             out_enabled;
    logic [11:0]             drive;
    logic [11:0]             read_bits;
    logic [DATA_W-1:0]       next_rd_data;

    ////////////////////////////////////////////////////////////////////
    // Per-pin gating and polarity
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
        assign fn_sel[g] = fn_reg[g / FN_PER_REG]
                                 [(g % FN_PER_REG) * FN_W +: FN_W];
        pin_level_cell u_cell (
            .i_level           (level[g]),
            .i_pin_in          (i_pin_in[g]),
            .i_polarity        (polarity[g]),
            .i_direction       (direction[g]),
            .i_function_select (fn_sel[g]),
            .o_out_enabled     (out_enabled[g]),
            .o_drive           (drive[g]),
            .o_read_bit        (read_bits[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Level bits: only output-enabled pins take a write; upper bits dropped
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            level <= LEVEL_RESET;
        end else if (i_wr_en && i_addr == PIN_LEVEL_ADDR) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (out_enabled[i]) begin
                    level[i] <= i_wr_data[i];
                end
            end
        end
    end

    // Direction and polarity settings
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            direction <= DIR_RESET;
            polarity  <= POL_RESET;
        end else if (i_wr_en) begin
            if (i_addr == PIN_DIR_ADDR) begin
                direction <= i_wr_data[11:0];
            end
            if (i_addr == PIN_POL_ADDR) begin
                polarity <= i_wr_data[11:0];
            end
        end
    end

    // Function selects, four pins to a register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fn_reg[0] <= FN_RESET;
            fn_reg[1] <= FN_RESET;
            fn_reg[2] <= FN_RESET;
        end else if (i_wr_en) begin
            case (i_addr)
                PIN_FN0_ADDR: fn_reg[0] <= i_wr_data;
                PIN_FN1_ADDR: fn_reg[1] <= i_wr_data;
                PIN_FN2_ADDR: fn_reg[2] <= i_wr_data;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses answer zero
    always_comb begin
        case (i_addr)
            // Pin input through polarity, upper bits zero
            PIN_LEVEL_ADDR: next_rd_data = {UPPER_ZERO, read_bits};
            PIN_DIR_ADDR:   next_rd_data = {UPPER_ZERO, direction};
            PIN_POL_ADDR:   next_rd_data = {UPPER_ZERO, polarity};
            PIN_FN0_ADDR:   next_rd_data = fn_reg[0];
            PIN_FN1_ADDR:   next_rd_data = fn_reg[1];
            PIN_FN2_ADDR:   next_rd_data = fn_reg[2];
            default:        next_rd_data = UNMAPPED_READ;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rd_data <= UNMAPPED_READ;
        end else if (i_rd_en) begin
            o_rd_data <= next_rd_data;
        end else begin
            o_rd_data <= UNMAPPED_READ;
        end
    end

    // Pin drivers are registered, so a change shows one cycle later
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pin_out <= LEVEL_RESET;
            o_pin_oe  <= LEVEL_RESET;
        end else begin
            o_pin_out <= drive;
            o_pin_oe  <= out_enabled;
        end
    end
endmodule : gpio_level_register

// ---- testbench/gpio_level_checker.sv ----
// Port checker for the pin level register.
// Assumes it is bound to every gpio_level_register.
`timescale 1ns/1ps
module gpio_level_checker
    import gpio_level_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_sys_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic              i_wr_en,
    input wire logic              i_rd_en,
    input wire logic [DATA_W-1:0] o_rd_data,
    input wire logic [11:0]       i_pin_in,
    input wire logic [11:0]       o_pin_out,
    input wire logic [11:0]       o_pin_oe
);
    logic [11:0] pol;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // Polarity shadow from bus writes, so no internal probing is needed
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) pol <= POL_RESET;
        else if (i_wr_en && i_addr == PIN_POL_ADDR) pol <= i_wr_data[11:0];
    end
    sequence s_lvl_wr; i_wr_en && i_addr == PIN_LEVEL_ADDR; endsequence
    sequence s_lvl_rd; i_rd_en && i_addr == PIN_LEVEL_ADDR; endsequence
    property p_oe;
        $changed(o_pin_oe) |-> $past(i_wr_en, 2) || $past(i_sys_rst);
    endproperty
    a_oe: assert property (p_oe) else $error("oe moved alone");
    property p_drv; s_lvl_wr |-> ##2
        ((o_pin_out ^ $past(i_wr_data[11:0], 2) ^ ~pol) & o_pin_oe) == 0;
    endproperty
    a_drv: assert property (p_drv) else $error("bad drive");
    property p_rd;
        s_lvl_rd |=> o_rd_data[11:0] == ($past(i_pin_in) ^ ~pol);
    endproperty
    a_rd: assert property (p_rd) else $error("bad level read");
    property p_top; i_rd_en |=> o_rd_data[15:12] == UPPER_ZERO; endproperty
    a_top: assert property (p_top) else $error("upper bits set");
    property p_idle; !i_rd_en |=> o_rd_data == '0; endproperty
    a_idle: assert property (p_idle) else $error("stale read data");
endmodule : gpio_level_checker
bind gpio_level_register gpio_level_checker i_gpio_level_checker (
    .i_clk, .i_sys_rst, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en,
    .o_rd_data, .i_pin_in, .o_pin_out, .o_pin_oe);

// ---- testbench/pin_world.sv ----
// Outside world of the twelve pins.
// Assumes the bench sets the outside level of undriven pins.
`timescale 1ns/1ps
module pin_world (
    input  wire logic [11:0] i_drive,
    input  wire logic [11:0] i_oe,
    input  wire logic [11:0] i_ext,
    output logic [11:0]      o_pin
);
    // A driven pin wins; contention is not modelled
    assign o_pin = (i_drive & i_oe) | (i_ext & ~i_oe);
endmodule : pin_world

// ---- testbench/tb.sv ----
// Bench: random settings, level writes and level reads against a model.
// Assumes the checker binds itself to the register.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
    import gpio_level_pkg::*;
    logic        i_clk = 0, i_sys_rst = 1, i_wr_en = 0, i_rd_en = 0;
    logic [15:0] i_addr = '0, i_wr_data = '0, o_rd_data, e;
    logic [11:0] ext = '0, pins, o_pin_out, o_pin_oe, pol, dir, lvl;
    logic [47:0] fn;
    int          n_errors = 0, n_compared = 0, seed = 8, cyc = 0;
    always #20 i_clk = ~i_clk;
    gpio_level_register i_gpio_level_register (.i_clk, .i_sys_rst, .i_addr,
        .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .i_pin_in(pins),
        .o_pin_out, .o_pin_oe);
    pin_world i_pin_world (.i_drive(o_pin_out), .i_oe(o_pin_oe),
        .i_ext(ext), .o_pin(pins));
    // Pins whose level writes reach the wire
    function automatic logic [11:0] en();
        for (int g = 0; g < 12; g++)
            en[g] = !dir[g] && fn[4*g+:4] == FN_PLAIN_GPIO;
    endfunction : en
    // One strobe cycle; a read checks d against the next cycle
    task automatic bus(input logic w, input logic [15:0] a, d);
        @(posedge i_clk);
        i_wr_en <= w;
        i_rd_en <= !w;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
        i_rd_en <= 1'b0;
        #1 if (!w) `CHK("rd_data", d, o_rd_data)
    endtask : bus
    // Level write uses the settings in force before it
    task automatic wr(input logic [15:0] a, d);
        bus(1, a, d);
        case (a)
            PIN_LEVEL_ADDR: lvl = lvl & ~en() | d[11:0] & en();
            PIN_DIR_ADDR:   dir = d[11:0];
            PIN_POL_ADDR:   pol = d[11:0];
            PIN_FN0_ADDR, PIN_FN1_ADDR, PIN_FN2_ADDR:
                fn[16*(a-PIN_FN0_ADDR)+:16] = d;
            default: ;
        endcase
    endtask : wr
    task automatic end_of_test();
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 5000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        {dir, pol, fn, lvl} = {DIR_RESET, POL_RESET, 48'h0, LEVEL_RESET};
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1 `CHK("oe", 12'h000, o_pin_oe)
        for (int k = 0; k < 8; k++) begin
            @(posedge i_clk);
            ext <= 12'($random(seed));
            wr(PIN_POL_ADDR, 16'($random(seed)));
            wr(PIN_DIR_ADDR, 16'($random(seed)));
            wr(PIN_FN0_ADDR + 16'(k % 3), 16'($random(seed)) & 16'h1111);
            wr(PIN_LEVEL_ADDR, 16'($random(seed)));
            @(posedge i_clk);
            #1 `CHK("oe", en(), o_pin_oe)
            `CHK("out", lvl ^ ~pol, o_pin_out)
            e = {4'h0, ((lvl ^ ~pol) & en() | ext & ~en()) ^ ~pol};
            bus(0, PIN_LEVEL_ADDR, e);
            bus(0, 16'h400d, 16'h0000);
        end
        end_of_test();
    end
endmodule : tb
